// File: hdl/dyn_mode_ctrl.sv
// dynamic mode, sample sync pulse, bioz range checks and serial commands
// assumes a serial host on sclk/csb_n/sdi and sample strobes from the core clock domain
//
// Functional notes
// - clear-mode 1 self-clears sync pulse after quarter cycle; 0 holds until status read
// - interval 00/01/10/11 issues pulse every 1st/2nd/4th/16th sample instant
// - recovery field: 00 off, 01 manual, 10 automatic, 11 reserved
// - auto: ecg beyond 2048*threshold over 125ms engages recovery for 500ms
// - leadoff enabled: bioz beyond 2048*over limit over 128ms sets over flag
// - leadoff enabled: bioz within 32*under limit over 128ms sets under flag
// - dynamic register writes need no resync and leave fifo alone
// - soft reset with zero data restores defaults at 32nd sclk edge
// - zero-data resync restarts channels at next master clock edge
// - resync also empties fifos and sets filters to midscale
// - resync leaves configuration registers unchanged
// - zero-data fifo restart empties fifos and resumes with next samples
// - fifo restart leaves running channel circuitry untouched
// - status read clears read-cleared flags at its 32nd sclk edge
`timescale 1ns/100ps
`default_nettype none
module dyn_mode_ctrl
    import dyn_mode_pkg::*;
#(
    parameter int    ECG_WIDTH     = 18,
    parameter int    BIOZ_WIDTH    = 20,
    parameter int    QUARTER_CYCLES = 1_000_000,
    parameter longint ECG_QUALIFY   = dyn_mode_pkg::ECG_QUALIFY_CYCLES,
    parameter longint BIOZ_QUALIFY  = dyn_mode_pkg::BIOZ_QUALIFY_CYCLES,
    parameter longint RECOVERY_HOLD = dyn_mode_pkg::RECOVERY_CYCLES
) (
    input  wire logic                         core_clk,
    input  wire logic                         srst,
    input  wire logic                         ce,
    input  wire logic                         sclk,
    input  wire logic                         csb_n,
    input  wire logic                         sdi,
    input  wire logic                         master_timing_clock,
    input  wire logic                         sample_instant,
    input  wire logic signed [ECG_WIDTH-1:0]  ecg_sample,
    input  wire logic signed [BIOZ_WIDTH-1:0] bioz_sample,
    input  wire logic [1:0]                   ac_leadoff_enable,
    output logic                              sample_sync_pulse,
    output logic                              fast_recovery_active,
    output logic                              bioz_over_range_flag,
    output logic                              bioz_under_range_flag,
    output logic                              device_reset,
    output logic                              channel_restart,
    output logic                              fifo_flush,
    output logic                              filter_midscale,
    output logic [23:0]                       interrupt_manager,
    output logic [23:0]                       dynamic_mode_manager
);
    import dyn_mode_pkg::*;

    initial
    begin
        if (ECG_WIDTH < 18 || BIOZ_WIDTH < 20 || QUARTER_CYCLES < 1)
            $error("dyn_mode_ctrl: widths or quarter count too small");
    end

    // ----------------------------------------------------------------
    // link side: frame capture on sclk
    // ----------------------------------------------------------------
    logic        frame_toggle;
    logic [6:0]  frame_addr;
    logic        frame_write;
    logic [23:0] frame_data;

    serial_frame_rx u_rx (
        .sclk         (sclk),
        .csb_n        (csb_n),
        .sdi          (sdi),
        .frame_toggle (frame_toggle),
        .frame_addr   (frame_addr),
        .frame_write  (frame_write),
        .frame_data   (frame_data)
    );

    // ----------------------------------------------------------------
    // crossing: toggle synchroniser, word stable while toggle settles
    // ----------------------------------------------------------------
    logic [2:0] toggle_sync_reg;
    logic       frame_done;
    logic [1:0] master_timing_clock_sync_reg;
    logic       master_timing_clock_last_reg;
    logic       master_timing_clock_edge;

    always_ff @(posedge core_clk)
    begin
        if (ce)
        begin
            toggle_sync_reg <= {toggle_sync_reg[1:0], frame_toggle};
            master_timing_clock_sync_reg   <= {master_timing_clock_sync_reg[0], master_timing_clock};
            master_timing_clock_last_reg   <= master_timing_clock_sync_reg[1];
        end
    end

    assign frame_done = toggle_sync_reg[1] & ~toggle_sync_reg[2];
    assign master_timing_clock_edge  = master_timing_clock_sync_reg[1] & ~master_timing_clock_last_reg;

    // ----------------------------------------------------------------
    // frame decode
    // ----------------------------------------------------------------
    logic data_zero;
    logic write_dyn;
    logic write_int;
    logic cmd_reset;
    logic cmd_resync;
    logic cmd_fifo;
    logic status_read;

    assign data_zero   = (frame_data == 24'h00_0000);
    assign write_int   = frame_done & frame_write & (frame_addr == ADDR_INTERRUPT_MANAGER);
    assign write_dyn   = frame_done & frame_write & (frame_addr == ADDR_DYNAMIC_MODE_MANAGER);
    assign cmd_reset   = frame_done & frame_write & data_zero
                         & (frame_addr == ADDR_SOFT_RESET_COMMAND);
    assign cmd_resync  = frame_done & frame_write & data_zero
                         & (frame_addr == ADDR_RESYNC_COMMAND);
    assign cmd_fifo    = frame_done & frame_write & data_zero
                         & (frame_addr == ADDR_FIFO_RESTART_COMMAND);
    assign status_read = frame_done & ~frame_write & (frame_addr == ADDR_STATUS);

    // ----------------------------------------------------------------
    // soft reset: one cycle, merged with srst for all core state except itself and the synchronisers
    // ----------------------------------------------------------------
    logic soft_reset_reg;
    logic rst;

    always_ff @(posedge core_clk)
    begin
        if (srst)
            soft_reset_reg <= 1'b0;
        else if (ce)
            soft_reset_reg <= cmd_reset;
    end

    assign rst          = srst | soft_reset_reg;
    assign device_reset = soft_reset_reg;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            interrupt_manager    <= INTERRUPT_MANAGER_RESET;
            dynamic_mode_manager <= DYNAMIC_MODE_MANAGER_RESET;
        end
        else if (ce)
        begin
            if (write_int)
                interrupt_manager <= frame_data;
            if (write_dyn)
                dynamic_mode_manager <= frame_data;
        end
    end

    logic       clear_mode;
    logic [1:0] interval;
    logic [1:0] recovery_field;
    logic [5:0] recovery_threshold;
    logic [7:0] bioz_over_range_limit;
    logic [7:0] bioz_under_range_limit;

    assign clear_mode             = interrupt_manager[CLEAR_MODE_BIT];
    assign interval               = interrupt_manager[INTERVAL_LSB +: 2];
    assign recovery_field         = dynamic_mode_manager[RECOVERY_LSB +: 2];
    assign recovery_threshold     = dynamic_mode_manager[THRESHOLD_LSB +: 6];
    assign bioz_over_range_limit  = dynamic_mode_manager[OVER_LIMIT_LSB +: 8];
    assign bioz_under_range_limit = dynamic_mode_manager[UNDER_LIMIT_LSB +: 8];

    // ----------------------------------------------------------------
    // resync: armed by command, fired at next master clock edge
    // ----------------------------------------------------------------
    logic resync_pending_reg;
    logic resync_fire;

    always_ff @(posedge core_clk)
    begin
        if (rst)
            resync_pending_reg <= 1'b0;
        else if (ce)
        begin
            if (cmd_resync)
                resync_pending_reg <= 1'b1;
            else if (master_timing_clock_edge)
                resync_pending_reg <= 1'b0;
        end
    end

    assign resync_fire = resync_pending_reg & master_timing_clock_edge;

    // config registers untouched; only operational strobes
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            channel_restart <= 1'b0;
            filter_midscale <= 1'b0;
            fifo_flush      <= 1'b0;
        end
        else if (ce)
        begin
            channel_restart <= resync_fire;
            filter_midscale <= resync_fire;
            fifo_flush      <= resync_fire | cmd_fifo;
        end
    end

    // ----------------------------------------------------------------
    // sample sync pulse
    // ----------------------------------------------------------------
    function automatic logic [3:0] interval_mask(input logic [1:0] code);
        unique case (code)
            2'b00: interval_mask = 4'h0;
            2'b01: interval_mask = 4'h1;
            2'b10: interval_mask = 4'h3;
            2'b11: interval_mask = 4'hF;
        endcase
    endfunction : interval_mask

    localparam int QW = $clog2(QUARTER_CYCLES + 1);
    logic [3:0]    sample_count_reg;
    logic [QW-1:0] pulse_timer_reg;
    logic          issue;

    assign issue = sample_instant & ((sample_count_reg & interval_mask(interval)) == 4'h0);

    always_ff @(posedge core_clk)
    begin
        if (rst || (ce && resync_fire))
            sample_count_reg <= 4'h0;
        else if (ce && sample_instant)
            sample_count_reg <= sample_count_reg + 4'h1;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            sample_sync_pulse <= 1'b0;
            pulse_timer_reg   <= '0;
        end
        else if (ce)
        begin
            if (issue)
            begin
                sample_sync_pulse <= 1'b1;
                pulse_timer_reg   <= QW'(QUARTER_CYCLES);
            end
            else if (clear_mode)
            begin
                if (pulse_timer_reg != '0)
                    pulse_timer_reg <= pulse_timer_reg - QW'(1);
                else
                    sample_sync_pulse <= 1'b0;
            end
            else if (status_read)
                sample_sync_pulse <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // fast recovery
    // ----------------------------------------------------------------
    recovery_mode_t recovery_mode;

    always_comb
    begin
        unique case (recovery_field)
            2'b01:   recovery_mode = RECOVERY_MANUAL;
            2'b10:   recovery_mode = RECOVERY_AUTO;
            default: recovery_mode = RECOVERY_OFF;
        endcase
    end

    function automatic logic beyond(input logic signed [23:0] value,
                                    input logic [23:0] limit);
        beyond = (value > $signed(limit)) || (value < -$signed(limit));
    endfunction : beyond

    logic [23:0] ecg_limit;
    logic        ecg_beyond;
    logic        ecg_qualified;

    assign ecg_limit  = 24'(recovery_threshold) << OVER_SCALE_SHIFT;
    assign ecg_beyond = (recovery_mode == RECOVERY_AUTO)
                        & beyond(24'(ecg_sample), ecg_limit);

    range_qualifier #(.CYCLES(int'(ECG_QUALIFY))) u_ecg_qual (
        .core_clk  (core_clk),
        .srst      (rst),
        .ce        (ce),
        .condition (ecg_beyond),
        .qualified (ecg_qualified)
    );

    localparam int RW = $clog2(RECOVERY_HOLD + 1);
    logic [RW-1:0] hold_reg;

    always_ff @(posedge core_clk)
    begin
        if (rst || (ce && recovery_mode != RECOVERY_AUTO))
            hold_reg <= '0;
        else if (ce)
        begin
            if (hold_reg == '0 && ecg_qualified)
                hold_reg <= RW'(RECOVERY_HOLD);
            else if (hold_reg != '0)
                hold_reg <= hold_reg - RW'(1);
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            fast_recovery_active <= 1'b0;
        else if (ce)
            fast_recovery_active <= (recovery_mode == RECOVERY_MANUAL) || (hold_reg != '0);
    end

    // ----------------------------------------------------------------
    // bioz ac lead-off range checks
    // ----------------------------------------------------------------
    logic [23:0] over_limit;
    logic [23:0] under_limit;
    logic        over_cond;
    logic        under_cond;
    logic        over_qualified;
    logic        under_qualified;

    assign over_limit  = 24'(bioz_over_range_limit) << OVER_SCALE_SHIFT;
    assign under_limit = 24'(bioz_under_range_limit) << UNDER_SCALE_SHIFT;
    assign over_cond   = ac_leadoff_enable[1] & beyond(24'(bioz_sample), over_limit);
    assign under_cond  = ac_leadoff_enable[1] & ~beyond(24'(bioz_sample), under_limit);

    range_qualifier #(.CYCLES(int'(BIOZ_QUALIFY))) u_over_qual (
        .core_clk  (core_clk),
        .srst      (rst),
        .ce        (ce),
        .condition (over_cond),
        .qualified (over_qualified)
    );

    range_qualifier #(.CYCLES(int'(BIOZ_QUALIFY))) u_under_qual (
        .core_clk  (core_clk),
        .srst      (rst),
        .ce        (ce),
        .condition (under_cond),
        .qualified (under_qualified)
    );

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            bioz_over_range_flag  <= 1'b0;
            bioz_under_range_flag <= 1'b0;
        end
        else if (ce)
        begin
            bioz_over_range_flag  <= over_qualified;
            bioz_under_range_flag <= under_qualified;
        end
    end

endmodule : dyn_mode_ctrl
`default_nettype wire

// File: hdl/dyn_mode_pkg.sv
// constants for the dynamic-mode and command block: register map, field layout, timing
// assumes a 250 MHz core clock and 24-bit register words behind a 32-clock serial frame
package dyn_mode_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [6:0] ADDR_INTERRUPT_MANAGER    = 7'h04;
    localparam logic [6:0] ADDR_DYNAMIC_MODE_MANAGER = 7'h05;
    localparam logic [6:0] ADDR_SOFT_RESET_COMMAND   = 7'h08;
    localparam logic [6:0] ADDR_RESYNC_COMMAND       = 7'h09;
    localparam logic [6:0] ADDR_FIFO_RESTART_COMMAND = 7'h0A;
    localparam logic [6:0] ADDR_STATUS               = 7'h01;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int CLEAR_MODE_BIT   = 2;
    localparam int INTERVAL_LSB     = 0;
    localparam int RECOVERY_LSB     = 22;
    localparam int THRESHOLD_LSB    = 16;
    localparam int OVER_LIMIT_LSB   = 8;
    localparam int UNDER_LIMIT_LSB  = 0;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [23:0] INTERRUPT_MANAGER_RESET    = 24'h7B_0004;
    localparam logic [23:0] DYNAMIC_MODE_MANAGER_RESET = 24'h3F_FFFF;

    // ----------------------------------------------------------------
    // thresholds scale factors
    // ----------------------------------------------------------------
    localparam int OVER_SCALE_SHIFT  = 11;
    localparam int UNDER_SCALE_SHIFT = 5;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam longint CORE_CLK_HZ        = 250_000_000;
    localparam longint QUALIFY_BIOZ_MS    = 128;
    localparam longint QUALIFY_ECG_MS     = 125;
    localparam longint RECOVERY_HOLD_MS   = 500;
    localparam longint BIOZ_QUALIFY_CYCLES = (QUALIFY_BIOZ_MS * CORE_CLK_HZ) / 1000;
    localparam longint ECG_QUALIFY_CYCLES  = (QUALIFY_ECG_MS * CORE_CLK_HZ) / 1000;
    localparam longint RECOVERY_CYCLES     = (RECOVERY_HOLD_MS * CORE_CLK_HZ) / 1000;
    localparam int     FRAME_BITS          = 32;

    typedef enum logic [2:0] {
        RECOVERY_OFF    = 3'b001,
        RECOVERY_MANUAL = 3'b010,
        RECOVERY_AUTO   = 3'b100
    } recovery_mode_t;

endpackage : dyn_mode_pkg

// File: hdl/range_qualifier.sv
// qualifies a condition held continuously for a programmed number of cycles
// assumes condition and clear come from the core clock domain
`timescale 1ns/100ps
`default_nettype none
module range_qualifier #(
    parameter int CYCLES = 32_000_000
) (
    input  wire logic core_clk,
    input  wire logic srst,
    input  wire logic ce,
    input  wire logic condition,
    output logic      qualified
);
    localparam int W = $clog2(CYCLES + 1);
    logic [W-1:0] count_reg;

    initial
    begin
        if (CYCLES < 1)
            $error("range_qualifier: CYCLES must be at least 1");
    end

    // qualified only after more than CYCLES consecutive cycles
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            count_reg <= '0;
            qualified <= 1'b0;
        end
        else if (ce)
        begin
            if (!condition)
            begin
                count_reg <= '0;
                qualified <= 1'b0;
            end
            else if (count_reg == W'(CYCLES))
                qualified <= 1'b1;
            else
                count_reg <= count_reg + W'(1);
        end
    end

endmodule : range_qualifier
`default_nettype wire

// File: hdl/serial_frame_rx.sv
// serial frame receiver on the link clock: 7-bit address, r/w bit, 24 data bits
// assumes csb_n low frames exactly 32 sclk rising edges; sclk stops between frames
`timescale 1ns/100ps
`default_nettype none
module serial_frame_rx
    import dyn_mode_pkg::*;
(
    input  wire logic        sclk,
    input  wire logic        csb_n,
    input  wire logic        sdi,
    output logic             frame_toggle,
    output logic [6:0]       frame_addr,
    output logic             frame_write,
    output logic [23:0]      frame_data
);
    logic [31:0] shift_reg;
    logic [5:0]  count_reg;
    logic [31:0] shift_next;

    assign shift_next = {shift_reg[30:0], sdi};

    // ----------------------------------------------------------------
    // shift and count; csb_n high clears the count asynchronously to the frame
    // ----------------------------------------------------------------
    always_ff @(posedge sclk or posedge csb_n)
    begin
        if (csb_n)
            count_reg <= 6'h00;
        else
            count_reg <= count_reg + 6'h01;
    end

    always_ff @(posedge sclk)
    begin
        shift_reg <= shift_next;
    end

    // latch word and signal at the 32nd rising edge
    always_ff @(posedge sclk)
    begin
        if (!csb_n && count_reg == 6'(FRAME_BITS - 1))
        begin
            frame_addr   <= shift_next[31:25];
            frame_write  <= ~shift_next[24];
            frame_data   <= shift_next[23:0];
        end
    end

    assign frame_toggle = count_reg[5]; // done level until csb_n rises

endmodule : serial_frame_rx
`default_nettype wire

// File: verif/dyn_mode_chk.sv
// checker for dyn_mode_ctrl: strobe pairing, defaults, mode and enable gating
// assumes ce high; bound to the design top
`timescale 1ns/100ps
`default_nettype none
module dyn_mode_chk
    import dyn_mode_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        srst,
    input wire logic        sample_instant,
    input wire logic [1:0]  ac_leadoff_enable,
    input wire logic        sample_sync_pulse,
    input wire logic        fast_recovery_active,
    input wire logic        bioz_over_range_flag,
    input wire logic        bioz_under_range_flag,
    input wire logic        device_reset,
    input wire logic        channel_restart,
    input wire logic        filter_midscale,
    input wire logic [23:0] interrupt_manager,
    input wire logic [23:0] dynamic_mode_manager
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    // ------------------------------------------------
    // assertions
    // ------------------------------------------------
    a_restart_pairs: assert property (channel_restart |-> filter_midscale)
        else $error("restart without midscale");
    a_resync_keeps_cfg: assert property (channel_restart |->
        $stable(interrupt_manager) && $stable(dynamic_mode_manager))
        else $error("resync altered registers");
    a_reset_defaults: assert property (device_reset |-> ##[0:2]
        (interrupt_manager == INTERRUPT_MANAGER_RESET
        && dynamic_mode_manager == DYNAMIC_MODE_MANAGER_RESET))
        else $error("soft reset missed defaults");
    a_reset_single: assert property (device_reset |=> !device_reset)
        else $error("soft reset strobe too long");
    a_over_needs_en: assert property ($rose(bioz_over_range_flag) |-> $past(ac_leadoff_enable[1]))
        else $error("over flag while disabled");
    a_under_needs_en: assert property ($rose(bioz_under_range_flag) |-> $past(ac_leadoff_enable[1]))
        else $error("under flag while disabled");
    a_pulse_follows: assert property ($rose(sample_sync_pulse) |->
        $past(sample_instant) || $past(sample_instant, 2))
        else $error("sync pulse without instant");
    a_manual_on: assert property ((dynamic_mode_manager[23:22] == 2'b01)[*4] |-> fast_recovery_active)
        else $error("manual recovery not active");
    a_off_idle: assert property ((dynamic_mode_manager[23:22] == 2'b00)[*4] |-> !fast_recovery_active)
        else $error("recovery active in normal mode");
    c_resync: cover property (channel_restart);
    c_reset: cover property (device_reset);
    c_over: cover property ($rose(bioz_over_range_flag));
    c_recovery: cover property ($rose(fast_recovery_active));
endmodule : dyn_mode_chk
bind dyn_mode_ctrl dyn_mode_chk u_chk (.core_clk(core_clk), .srst(srst),
    .sample_instant(sample_instant), .ac_leadoff_enable(ac_leadoff_enable),
    .sample_sync_pulse(sample_sync_pulse), .fast_recovery_active(fast_recovery_active),
    .bioz_over_range_flag(bioz_over_range_flag), .bioz_under_range_flag(bioz_under_range_flag),
    .device_reset(device_reset), .channel_restart(channel_restart),
    .filter_midscale(filter_midscale), .interrupt_manager(interrupt_manager),
    .dynamic_mode_manager(dynamic_mode_manager));
`default_nettype wire

// File: verif/spi_host_model.sv
// host model: 32-bit serial frames, msb first, data changed while sclk low
// assumes the bench calls send(); sclk rests low between frames
`timescale 1ns/100ps
`default_nettype none
module spi_host_model #(
    parameter real HALF = 24.0
) (
    output var logic sclk,
    output var logic csb_n,
    output var logic sdi
);
    initial
    begin
        sclk  = 1'b0;
        #1 csb_n = 1'b1;
        sdi   = 1'b1;
    end
    // ------------------------------------------------
    // one frame, then an idle gap in ns
    // ------------------------------------------------
    task automatic send(input logic [31:0] word, input int gap);
        #(7.3);
        csb_n = 1'b0;
        for (int i = 31; i >= 0; i--)
        begin
            sdi = word[i];
            #(HALF) sclk = 1'b1;
            #(HALF) sclk = 1'b0;
        end
        #(HALF) csb_n = 1'b1;
        sdi = ~sdi;
        #(gap);
    endtask : send
endmodule : spi_host_model
`default_nettype wire

// File: verif/tb_dyn_mode_ctrl.sv
// self-checking bench for dyn_mode_ctrl with a serial host model
// assumes shortened qualification and hold parameters
`timescale 1ns/100ps
`default_nettype none
module tb_dyn_mode_ctrl;
    import dyn_mode_pkg::*;
    localparam int QC = 20;
    logic core_clk = 0, srst = 1, mtc = 0, inst = 0, inst_en = 1, pp = 0;
    logic signed [17:0] ecg = 0;
    logic signed [19:0] bioz = 0;
    logic [1:0]  ale = 0;
    logic [31:0] seed = 90275, r;
    logic [23:0] im, dm, v;
    logic        sp, fr, ov, un, dr, cr, ff, fm;
    wire logic   sclk, csb_n, sdi;
    int          error_cnt = 0, checks = 0, n_sp = 0, n_dr = 0, n_cr = 0, n_ff = 0, ph = 0, s;
    realtime     t_mt = 0, d_cr = 0;
    spi_host_model u_host (.sclk(sclk), .csb_n(csb_n), .sdi(sdi));
    dyn_mode_ctrl #(.QUARTER_CYCLES(8), .ECG_QUALIFY(QC), .BIOZ_QUALIFY(QC),
        .RECOVERY_HOLD(40)) u_dut (.core_clk(core_clk), .srst(srst), .ce(1'b1),
        .sclk(sclk), .csb_n(csb_n), .sdi(sdi), .master_timing_clock(mtc),
        .sample_instant(inst), .ecg_sample(ecg), .bioz_sample(bioz),
        .ac_leadoff_enable(ale), .sample_sync_pulse(sp), .fast_recovery_active(fr),
        .bioz_over_range_flag(ov), .bioz_under_range_flag(un), .device_reset(dr),
        .channel_restart(cr), .fifo_flush(ff), .filter_midscale(fm),
        .interrupt_manager(im), .dynamic_mode_manager(dm));
    always #2 core_clk = ~core_clk;
    always #200 mtc = ~mtc;
    always @(posedge mtc) t_mt = $realtime;
    always @(posedge core_clk)
    begin
        n_sp += int'(sp && !pp);
        pp = sp;
        n_dr += int'(dr);
        n_cr += int'(cr);
        n_ff += int'(ff);
        if (cr) d_cr = $realtime - t_mt;
        #1;
        ph = (ph + 1) % 10;
        inst = inst_en && ph == 0;
    end
    // ------------------------------------------------
    // helpers
    // ------------------------------------------------
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function int pulses(input int k);
        return 32 / (k == 3 ? 16 : 1 << k);
    endfunction : pulses
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc
    task wr(input logic [6:0] a, input logic [23:0] d, input logic rd = 0);
        u_host.send({a, rd, d}, 20);
        cyc(8);
    endtask : wr
    task test_done();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done
    initial
    begin
        #200_000;
        error_cnt++;
        test_done();
    end
    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    initial
    begin
        cyc(5);
        srst = 0;
        chk(im, INTERRUPT_MANAGER_RESET);
        chk(dm, DYNAMIC_MODE_MANAGER_RESET);
        for (int k = 0; k < 4; k++)
        begin
            r = rnd();
            wr(ADDR_INTERRUPT_MANAGER, {r[23:8], 5'h00, 1'b1, k[1:0]});
            chk(im & 24'hFF_0007, {r[23:16], 13'h0000, 1'b1, k[1:0]});
            s = n_sp;
            cyc(320);
            chk(n_sp - s, pulses(k));
        end
        wr(ADDR_INTERRUPT_MANAGER, 24'h00_0000);
        cyc(15);
        inst_en = 0;
        cyc(30);
        chk(sp, 1);
        wr(ADDR_STATUS, 24'h00_0000, 1);
        chk(sp, 0);
        inst_en = 1;
        r = rnd();
        v = {2'b10, 6'h01, r[15:0]};
        s = n_ff + n_cr;
        wr(ADDR_DYNAMIC_MODE_MANAGER, v);
        chk(dm, v);
        chk(n_ff + n_cr - s, 0);
        ecg = 18'sd2048;
        cyc(40);
        chk(fr, 0);
        ecg = -18'sd3000;
        cyc(QC - 8);
        ecg = 0;
        cyc(5);
        chk(fr, 0);
        ecg = -18'sd3000;
        cyc(QC + 6);
        chk(fr, 1);
        ecg = 0;
        cyc(25);
        chk(fr, 1);
        cyc(30);
        chk(fr, 0);
        wr(ADDR_DYNAMIC_MODE_MANAGER, 24'h7F_FFFF);
        chk(fr, 1);
        v = {2'b00, 6'h3F, 8'h01, 8'h04};
        wr(ADDR_DYNAMIC_MODE_MANAGER, v);
        chk(fr, 0);
        ale = 2'b01;
        bioz = 20'sd5000;
        cyc(40);
        chk(ov, 0);
        bioz = 20'sd100;
        cyc(40);
        chk(un, 0);
        ale = 2'b10;
        bioz = -20'sd5000;
        cyc(40);
        chk(ov, 1);
        bioz = 20'sd127;
        cyc(40);
        chk(un, 1);
        s = n_dr + n_cr + n_ff;
        for (int k = 0; k < 3; k++)
        begin
            r = rnd();
            wr(ADDR_SOFT_RESET_COMMAND + 7'(k), r[23:0] | 24'h00_0001);
        end
        chk(n_dr + n_cr + n_ff - s, 0);
        s = n_cr;
        wr(ADDR_FIFO_RESTART_COMMAND, 24'h00_0000);
        chk(n_ff, 1);
        chk(n_cr - s, 0);
        chk(dm, v);
        wr(ADDR_RESYNC_COMMAND, 24'h00_0000);
        cyc(120);
        chk(n_cr - s, 1);
        chk(d_cr <= 32.0, 1);
        chk(n_ff, 2);
        chk(dm, v);
        wr(ADDR_SOFT_RESET_COMMAND, 24'h00_0000);
        chk(n_dr, 1);
        chk(im, INTERRUPT_MANAGER_RESET);
        chk(dm, DYNAMIC_MODE_MANAGER_RESET);
        test_done();
    end
endmodule : tb_dyn_mode_ctrl
`default_nettype wire
